// file: shared/its_line_if.sv
// Purpose: Carries the conditioned bus line events to the slave logic.
// Assumes: All signals are on the system clock.
// Notes:   Events are one-cycle pulses; levels are synchronised copies.
`timescale 1ns/1ns
interface its_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	modport prod (output scl, sda, scl_rise, scl_fall, start, stop);
	modport cons (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// file: shared/its_pkg.sv
// Purpose: Constants and types shared by the two-wire slave transmit path.
// Assumes: Byte addresses on a 32-bit AHB-Lite register bus.
// Notes:   Every offset lives here, with most field positions and the CTRL1, mask and own-address reset values.
package its_pkg;
	localparam logic [7:0] OFS_CTRL1   = 8'h00;
	localparam logic [7:0] OFS_STAT    = 8'h04;
	localparam logic [7:0] OFS_DATA    = 8'h08;
	localparam logic [7:0] OFS_CTRL2   = 8'h0c;
	localparam logic [7:0] OFS_CTRL3   = 8'h10;
	localparam logic [7:0] OFS_ISTAT   = 8'h14;
	localparam logic [7:0] OFS_IMASK   = 8'h18;
	localparam logic [7:0] OFS_OWNADDR = 8'h1c;

	localparam int C1_WRITE_COLLISION_FLAG = 7;
	localparam int C1_OV   = 6;
	localparam int C1_EN   = 5;
	localparam int C1_CKP  = 4;
	localparam int ST_P    = 4;
	localparam int ST_S    = 3;
	localparam int ST_RW   = 2;
	localparam int ST_BF   = 0;
	localparam int C2_ACK  = 6;
	localparam int C3_SCIE = 5;
	localparam int C3_SBCD = 2;
	localparam int IRQ_PORT = 0;
	localparam int IRQ_COLL = 1;

	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [6:0] OWN_RST   = 7'h00;
	localparam logic [1:0] MASK_RST  = 2'h0;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [2:0] LAST_BIT  = 3'h7;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ADDR_ACK,
		S_DATA,
		S_MACK
	} its_state_e;
endpackage

// file: src/its_line_mon.sv
// Purpose: Synchronise the bus lines and find their edges and conditions.
// Assumes: Bus clock well below a quarter of the system clock.
// Notes:   The first stage of each synchroniser feeds only the second.
`timescale 1ns/1ns
module its_line_mon (
	input  wire logic i_clk,
	input  wire logic i_srst,
	input  wire logic i_scl,
	input  wire logic i_sda,
	its_line_if.prod  o_ln
);
	import its_pkg::*;

	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic       scl_prev_r;
	logic       sda_prev_r;

	// Lines idle high, so reset to one to avoid a false edge.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], i_scl};
			sda_sync_r <= {sda_sync_r[0], i_sda};
			scl_prev_r <= scl_sync_r[1];
			sda_prev_r <= sda_sync_r[1];
		end
	end

	assign o_ln.scl      = scl_sync_r[1];
	assign o_ln.sda      = sda_sync_r[1];
	assign o_ln.scl_rise = scl_sync_r[1] & ~scl_prev_r;
	assign o_ln.scl_fall = ~scl_sync_r[1] & scl_prev_r;
	// A data change while the clock stays high marks start or stop.
	assign o_ln.start = scl_sync_r[1] & scl_prev_r & ~sda_sync_r[1]
		& sda_prev_r;
	assign o_ln.stop  = scl_sync_r[1] & scl_prev_r & sda_sync_r[1]
		& ~sda_prev_r;
endmodule // its_line_mon

// file: src/its_slave_tx.sv
// Purpose: Two-wire bus target that returns bytes to a reading master.
// Assumes: Single AHB-Lite slave; the master supplies the bus clock.
// Notes:   Open-drain pins: an enable high pulls the line low.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - Matching address with read direction sets the read/write status bit.
// - Matching read address goes to data buffer; acknowledge on ninth clock.
// - After address acknowledge, clear clock release and hold clock low.
// - Writing the data buffer also loads the shift register.
// - Data bits shift out on falling clock edges.
// - Master acknowledge latched on ninth rising edge into ack status.
// - Not-acknowledge ends the transfer and returns to idle.
// - Port interrupt flag set on ninth falling edge; software clears it.
// - After master not-acknowledge, no stretch but flag still set.
// - Enabled collision while sending sets collision flag, returns idle.
// - Start sets start bit; flag only when start interrupt enabled.
// - Reading the received address clears buffer full.
// - Stop leaves the device unaddressed; a repeated start goes back to address reception.
// - Port enable hands the pins to the port; clear returns them.
module its_slave_tx #(
	parameter int HADDR_W = 8
) (
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	input  wire logic               i_hsel,
	input  wire logic [HADDR_W-1:0] i_haddr,
	input  wire logic [1:0]         i_htrans,
	input  wire logic               i_hwrite,
	input  wire logic [2:0]         i_hsize,
	input  wire logic [31:0]        i_hwdata,
	input  wire logic               i_hready,
	output logic      [31:0]        o_hrdata,
	output logic                    o_hreadyout,
	output logic                    o_hresp,
	input  wire logic               i_scl,
	input  wire logic               i_sda,
	output logic                    o_scl_o,
	output logic                    o_scl_oe,
	output logic                    o_sda_o,
	output logic                    o_sda_oe,
	output logic                    o_pins_owned,
	output logic                    o_irq
);
	import its_pkg::*;

	if (HADDR_W < 8) begin : g_chk
		$error("HADDR_W must be at least 8");
	end

	its_line_if ln ();

	its_line_mon u_mon (
		.i_clk  (i_clk),
		.i_srst (i_srst),
		.i_scl  (i_scl),
		.i_sda  (i_sda),
		.o_ln   (ln)
	);

	its_state_e state_r;
	logic       en_r;
	logic       ckp_r;
	logic [3:0] mode_r;
	logic       write_collision_flag_r;
	logic       ov_r;
	logic       rw_r;
	logic       s_r;
	logic       p_r;
	logic       bf_r;
	logic       ack_r;
	logic       scie_r;
	logic       slave_collision_detect_enable_r;
	logic       pif_r;
	logic       bcl_r;
	logic [1:0] mask_r;
	logic [6:0] own_r;
	logic [7:0] buf_r;
	logic [7:0] shift_r;
	logic [3:0] cnt_r;
	logic       dsel_r;
	logic       dwr_r;
	logic [7:0] daddr_r;

	logic wr_c1;
	logic wr_data;
	logic rd_data;
	logic wr_c3;
	logic wr_ist;
	logic wr_msk;
	logic wr_own;
	logic data_busy;
	logic data_load;
	logic addr_match;
	logic ack_fall;
	logic mack_fall;
	logic coll;
	logic go_idle;

	// Address phase is captured once the bus is ready.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			dsel_r  <= 1'b0;
			dwr_r   <= 1'b0;
			daddr_r <= 8'h00;
		end else if (i_hready) begin
			dsel_r  <= i_hsel & i_htrans[1];
			dwr_r   <= i_hwrite;
			daddr_r <= i_haddr[7:0];
		end
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	always_comb begin
		wr_c1   = 1'b0;
		wr_data = 1'b0;
		rd_data = 1'b0;
		wr_c3   = 1'b0;
		wr_ist  = 1'b0;
		wr_msk  = 1'b0;
		wr_own  = 1'b0;
		if (daddr_r == OFS_CTRL1) begin
			wr_c1 = dsel_r & dwr_r;
		end else if (daddr_r == OFS_DATA) begin
			wr_data = dsel_r & dwr_r;
			rd_data = dsel_r & ~dwr_r;
		end else if (daddr_r == OFS_CTRL3) begin
			wr_c3 = dsel_r & dwr_r;
		end else if (daddr_r == OFS_ISTAT) begin
			wr_ist = dsel_r & dwr_r;
		end else if (daddr_r == OFS_IMASK) begin
			wr_msk = dsel_r & dwr_r;
		end else if (daddr_r == OFS_OWNADDR) begin
			wr_own = dsel_r & dwr_r;
		end
	end

	// Unmapped offsets read as zero; writes to them are dropped.
	always_comb begin
		o_hrdata = 32'h0000_0000;
		if (daddr_r == OFS_CTRL1) begin
			o_hrdata[7:0] = {write_collision_flag_r, ov_r, en_r, ckp_r, mode_r};
		end else if (daddr_r == OFS_STAT) begin
			o_hrdata[ST_P]  = p_r;
			o_hrdata[ST_S]  = s_r;
			o_hrdata[ST_RW] = rw_r;
			o_hrdata[ST_BF] = bf_r;
		end else if (daddr_r == OFS_DATA) begin
			o_hrdata[7:0] = buf_r;
		end else if (daddr_r == OFS_CTRL2) begin
			o_hrdata[C2_ACK] = ack_r;
		end else if (daddr_r == OFS_CTRL3) begin
			o_hrdata[C3_SCIE] = scie_r;
			o_hrdata[C3_SBCD] = slave_collision_detect_enable_r;
		end else if (daddr_r == OFS_ISTAT) begin
			o_hrdata[IRQ_PORT] = pif_r;
			o_hrdata[IRQ_COLL] = bcl_r;
		end else if (daddr_r == OFS_IMASK) begin
			o_hrdata[1:0] = mask_r;
		end else if (daddr_r == OFS_OWNADDR) begin
			o_hrdata[6:0] = own_r;
		end
	end

	// A buffer write while the master clocks a byte out would corrupt it.
	assign data_busy  = (state_r == S_DATA) && ckp_r;
	assign data_load  = wr_data && !data_busy;
	assign addr_match = (shift_r[7:1] == own_r) && shift_r[0];
	assign ack_fall   = (state_r == S_ADDR_ACK) && ln.scl_fall;
	assign mack_fall  = (state_r == S_MACK) && ln.scl_fall;
	assign coll = (state_r == S_DATA) && ln.scl_rise && shift_r[7]
		&& !ln.sda && slave_collision_detect_enable_r;
	assign go_idle = !en_r || ln.stop;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= S_IDLE;
			cnt_r   <= 4'h0;
		end else if (go_idle) begin
			state_r <= S_IDLE;
			cnt_r   <= 4'h0;
		end else if (ln.start) begin
			state_r <= S_ADDR;
			cnt_r   <= 4'h0;
		end else begin
			case (state_r)
				S_ADDR: begin
					if (ln.scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (ln.scl_fall && cnt_r == BITS_BYTE) begin
						state_r <= addr_match ? S_ADDR_ACK : S_IDLE;
					end
				end
				S_ADDR_ACK: begin
					if (ln.scl_fall) begin
						state_r <= S_DATA;
						cnt_r   <= 4'h0;
					end
				end
				S_DATA: begin
					if (coll) begin
						state_r <= S_IDLE;
					end else if (ln.scl_fall) begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r[2:0] == LAST_BIT) begin
							state_r <= S_MACK;
						end
					end
				end
				S_MACK: begin
					if (ln.scl_fall) begin
						cnt_r   <= 4'h0;
						state_r <= ack_r ? S_IDLE : S_DATA;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// One shifter serves both the incoming address and outgoing data.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			shift_r <= 8'h00;
		end else if (state_r == S_ADDR && ln.scl_rise && !ln.start) begin
			shift_r <= {shift_r[6:0], ln.sda};
		end else if (state_r == S_DATA && ln.scl_fall) begin
			shift_r <= {shift_r[6:0], 1'b0};
		end else if (data_load) begin
			shift_r <= i_hwdata[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			buf_r <= 8'h00;
			bf_r  <= 1'b0;
			rw_r  <= 1'b0;
		end else if (state_r == S_ADDR && ln.scl_fall
			&& cnt_r == BITS_BYTE && addr_match && en_r) begin
			buf_r <= shift_r;
			bf_r  <= 1'b1;
			rw_r  <= 1'b1;
		end else begin
			if (data_load) begin
				buf_r <= i_hwdata[7:0];
			end
			if (rd_data) begin
				bf_r <= 1'b0;
			end
			if (go_idle) begin
				rw_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ack_r <= 1'b0;
		end else if (state_r == S_MACK && ln.scl_rise) begin
			ack_r <= ln.sda;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			{write_collision_flag_r, ov_r, en_r, ckp_r, mode_r} <= CTRL1_RST;
		end else begin
			if (wr_c1) begin
				en_r   <= i_hwdata[C1_EN];
				ckp_r  <= i_hwdata[C1_CKP];
				mode_r <= i_hwdata[3:0];
				ov_r   <= ov_r & i_hwdata[C1_OV];
				write_collision_flag_r <= write_collision_flag_r & i_hwdata[C1_WRITE_COLLISION_FLAG];
			end
			// Hardware events win over a software write in the same cycle.
			if (wr_data && data_busy) begin
				write_collision_flag_r <= 1'b1;
			end
			if (ack_fall || (mack_fall && !ack_r)) begin
				ckp_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_r     <= 1'b0;
			p_r     <= 1'b0;
			scie_r  <= 1'b0;
			slave_collision_detect_enable_r <= 1'b0;
			mask_r  <= MASK_RST;
			own_r   <= OWN_RST;
		end else begin
			if (wr_c3) begin
				scie_r  <= i_hwdata[C3_SCIE];
				slave_collision_detect_enable_r <= i_hwdata[C3_SBCD];
			end
			if (wr_msk) begin
				mask_r <= i_hwdata[1:0];
			end
			if (wr_own) begin
				own_r <= i_hwdata[6:0];
			end
			if (!en_r) begin
				s_r <= 1'b0;
				p_r <= 1'b0;
			end else if (ln.start) begin
				s_r <= 1'b1;
				p_r <= 1'b0;
			end else if (ln.stop) begin
				s_r <= 1'b0;
				p_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pif_r <= 1'b0;
			bcl_r <= 1'b0;
		end else begin
			if (ack_fall || mack_fall || (ln.start && scie_r && en_r)) begin
				pif_r <= 1'b1;
			end else if (wr_ist && i_hwdata[IRQ_PORT]) begin
				pif_r <= 1'b0;
			end
			if (coll && en_r) begin
				bcl_r <= 1'b1;
			end else if (wr_ist && i_hwdata[IRQ_COLL]) begin
				bcl_r <= 1'b0;
			end
		end
	end

	assign o_irq = |({bcl_r, pif_r} & mask_r);

	// The clock is held only between bytes, before software releases it.
	assign o_scl_o      = 1'b0;
	assign o_sda_o      = 1'b0;
	assign o_pins_owned = en_r;
	assign o_scl_oe     = en_r && (state_r == S_DATA) && !ckp_r;
	assign o_sda_oe     = en_r && ((state_r == S_ADDR_ACK)
		|| (state_r == S_DATA && !shift_r[7]));

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	a_read_addr_hit: assert property ($rose(state_r == S_ADDR_ACK)
		|-> rw_r && bf_r && buf_r[0])
		else $error("read address did not set status");
	a_addr_ack_drv: assert property (state_r == S_ADDR_ACK && !ln.scl_fall
		|=> o_sda_oe)
		else $error("address acknowledge not driven");
	a_stretch_on: assert property (ack_fall && !wr_c1 && en_r
		|=> !ckp_r && o_scl_oe)
		else $error("clock not stretched after address");
	a_write_load: assert property (data_load && !(state_r == S_ADDR)
		&& !ln.scl_fall |=> shift_r == $past(i_hwdata[7:0]))
		else $error("buffer write missed shift register");
	a_shift_fall: assert property (state_r == S_DATA && ln.scl_fall
		&& en_r && !ln.start && !ln.stop
		|=> shift_r == {$past(shift_r[6:0]), 1'b0})
		else $error("data bit not shifted on falling edge");
	a_ack_latch: assert property (state_r == S_MACK && ln.scl_rise
		|=> ack_r == $past(ln.sda))
		else $error("master acknowledge not latched");
	a_nack_idle: assert property (mack_fall && ack_r && en_r
		&& !ln.start |=> state_r == S_IDLE && !o_scl_oe ##1 !o_scl_oe)
		else $error("not-acknowledge did not end transfer");
	a_byte_flag: assert property (mack_fall |=> pif_r)
		else $error("byte flag not set");
	a_coll_idle: assert property (coll && en_r
		|=> bcl_r && state_r == S_IDLE && !o_sda_oe)
		else $error("collision not handled");
	a_start_bit: assert property (ln.start && en_r |=> s_r
		&& (pif_r || !$past(scie_r)) && state_r != S_IDLE)
		else $error("start not recorded");
	a_bf_clear: assert property (rd_data && state_r != S_ADDR
		|=> !bf_r)
		else $error("buffer full not cleared");
	a_stop_idle: assert property (ln.stop |=> state_r == S_IDLE
		&& !rw_r)
		else $error("stop did not end addressing");
	a_off_quiet: assert property (!en_r |-> (!o_sda_oe && !o_scl_oe
		&& !o_pins_owned) ##1 state_r == S_IDLE)
		else $error("disabled port touches the bus");

	c_ack_byte: cover property (mack_fall && !ack_r);
	c_nack_byte: cover property (mack_fall && ack_r);
	c_collision: cover property (coll && en_r);
	c_start_irq: cover property (ln.start && scie_r && en_r);
endmodule // its_slave_tx

// file: verification/its_bus_master.sv
// Purpose: Behavioural two-wire bus master that reads bytes from the target.
// Assumes: Open-drain lines with pull-ups; bus clock period of eight cycles.
// Notes:   A 1 on an output releases the line; the clock is still between
//          frames, and the target may stretch the low phase before any bit.
`timescale 1ns/1ns
module its_bus_master (
	input  wire logic i_clk,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	logic [7:0] got [0:1];

	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic half();
		repeat (4) @(posedge i_clk);
	endtask

	task automatic bitx(input logic b, output logic r);
		@(posedge i_clk) o_sda <= b;
		repeat (3) @(posedge i_clk);
		o_scl <= 1'b1;
		// A held clock blocks the next pulse until the target lets go.
		do @(posedge i_clk); while (i_scl !== 1'b1);
		repeat (2) @(posedge i_clk);
		r = i_sda;
		@(posedge i_clk) o_scl <= 1'b0;
	endtask

	task automatic read_txn(input logic [6:0] a, input logic rw,
		input logic [7:0] drv, output logic aok);
		logic       r;
		logic [7:0] v;
		@(posedge i_clk) o_sda <= 1'b1;
		half();
		o_scl <= 1'b1;
		half();
		o_sda <= 1'b0;
		half();
		o_scl <= 1'b0;
		v = {a, rw};
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, r);
		aok = !r;
		if (aok) begin
			for (int k = 0; k < 2; k++) begin
				for (int i = 7; i >= 0; i--) begin
					bitx(k == 0 ? drv[i] : 1'b1, r);
					v[i] = r;
				end
				got[k] = v;
				// The last byte is refused to end the read.
				bitx(k == 1, r);
			end
		end
		// Every frame ends with a stop condition.
		@(posedge i_clk) o_sda <= 1'b0;
		half();
		o_scl <= 1'b1;
		half();
		o_sda <= 1'b1;
		half();
	endtask
endmodule // its_bus_master

// file: verification/test_its_slave_tx.sv
// Purpose: Self-checking bench for the two-wire slave transmit path.
// Assumes: Registers reached over AHB-Lite with no wait states.
// Notes:   Bytes and the own address are random from a fixed seed.
`timescale 1ns/1ns
module test_its_slave_tx;
	import its_pkg::*;
	logic        clk;
	logic        srst;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [7:0]  haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	wire logic   hready;
	logic        scl_oe;
	logic        sda_oe;
	logic        owned;
	logic        irq;
	logic        m_scl;
	logic        m_sda;
	logic        aok;
	logic [31:0] q;
	logic [6:0]  own;
	logic [7:0]  tx [0:1];
	integer      seed;
	int          failures;
	int          checked;
	int          cyc;
	logic        hresp;
	logic        scl_o;
	logic        sda_o;
	// A pin pulls low only while its enable is set and its value is low.
	wire logic   scl_w = m_scl & (~scl_oe | scl_o);
	wire logic   sda_w = m_sda & (~sda_oe | sda_o);

	its_slave_tx dut (
		.i_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .i_scl(scl_w),
		.i_sda(sda_w), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe),
		.o_pins_owned(owned), .o_irq(irq)
	);

	its_bus_master m (
		.i_clk(clk), .i_scl(scl_w), .i_sda(sda_w),
		.o_scl(m_scl), .o_sda(m_sda)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] bitv(input int p);
		return 32'h1 << p;
	endfunction

	function automatic logic [31:0] addr_byte(input logic [6:0] a,
		input logic rw);
		return {24'h0, a, rw};
	endfunction

	task automatic summarize();
		$display("comparisons %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// The ceiling is far above the thousand or so cycles the run needs.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			summarize();
		end
	end

	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		ahb(1'b0, a, 32'h0, r);
	endtask

	// One edge first, so a clear written just before has landed.
	task automatic wirq();
		@(posedge clk);
		while (irq !== 1'b1)
			@(posedge clk);
	endtask

	task automatic serve(input logic coll);
		wirq();
		rd(OFS_STAT, q);
		chk("start seen", q & bitv(ST_S), bitv(ST_S));
		wr(OFS_ISTAT, bitv(IRQ_PORT));
		wirq();
		rd(OFS_STAT, q);
		chk("rw bf", q & 32'h5, bitv(ST_RW) | bitv(ST_BF));
		wr(OFS_ISTAT, bitv(IRQ_PORT));
		chk("hold", {31'h0, scl_oe}, 32'h1);
		rd(OFS_DATA, q);
		chk("addr", q, addr_byte(own, 1'b1));
		rd(OFS_STAT, q);
		chk("bf clear", q & bitv(ST_BF), 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(OFS_DATA, {24'h0, tx[i]});
			wr(OFS_CTRL1, bitv(C1_EN) | bitv(C1_CKP));
			if (i == 0 && !coll) begin
				// A buffer write while the byte is on the wire is dropped.
				wr(OFS_DATA, 32'h0);
				rd(OFS_CTRL1, q);
				chk("write_collision_flag set", q & 32'hb0, 32'hb0);
				wr(OFS_CTRL1, bitv(C1_EN) | bitv(C1_CKP));
				rd(OFS_CTRL1, q);
				chk("write_collision_flag clear", q & 32'hb0, 32'h30);
			end
			wirq();
			if (coll) begin
				rd(OFS_ISTAT, q);
				chk("coll", q & 32'h2, 32'h2);
				wr(OFS_IMASK, 32'h1);
				@(posedge clk);
				chk("masked", {31'h0, irq}, 32'h0);
				wr(OFS_IMASK, 32'h3);
				@(posedge clk);
				chk("unmasked", {31'h0, irq}, 32'h1);
				wr(OFS_ISTAT, 32'h2);
				@(posedge clk);
				chk("cleared", {31'h0, irq}, 32'h0);
				break;
			end
			rd(OFS_CTRL2, q);
			chk("ack", q & bitv(C2_ACK), i ? bitv(C2_ACK) : 32'h0);
			chk("stretch", {31'h0, scl_oe}, {31'h0, i == 0});
			wr(OFS_ISTAT, bitv(IRQ_PORT));
		end
	endtask

	initial begin
		seed = 32'h9326;
		srst = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 8'h00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		failures = 0;
		checked = 0;
		cyc = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		rd(OFS_CTRL1, q);
		chk("ctrl1 reset", q, {24'h0, CTRL1_RST});
		rd(OFS_IMASK, q);
		chk("mask reset", q, {30'h0, MASK_RST});
		rd(8'h40, q);
		chk("unmapped", q, 32'h0);
		chk("bus pins", {29'h0, hresp, scl_o, sda_o}, 32'h0);
		own = 7'($random(seed));
		tx[0] = 8'($random(seed));
		tx[1] = 8'($random(seed));
		wr(OFS_OWNADDR, {25'h0, own});
		wr(OFS_IMASK, 32'h3);
		wr(OFS_CTRL3, bitv(C3_SCIE) | bitv(C3_SBCD));
		wr(OFS_CTRL1, bitv(C1_EN));
		repeat (2) @(posedge clk);
		chk("owned", {31'h0, owned}, 32'h1);
		fork
			m.read_txn(own, 1'b1, 8'hff, aok);
			serve(1'b0);
		join
		chk("addr ack", {31'h0, aok}, 32'h1);
		chk("byte0", {24'h0, m.got[0]}, {24'h0, tx[0]});
		chk("byte1", {24'h0, m.got[1]}, {24'h0, tx[1]});
		rd(OFS_STAT, q);
		chk("stop", q & 32'h14, bitv(ST_P));
		tx[0] = 8'hff;
		fork
			m.read_txn(own, 1'b1, 8'h7f, aok);
			serve(1'b1);
		join
		// Wrong address, write direction, then a disabled port.
		for (int k = 0; k < 3; k++) begin
			wr(OFS_ISTAT, 32'h3);
			wr(OFS_CTRL1, k == 2 ? 32'h0 : bitv(C1_EN));
			repeat (2) @(posedge clk);
			chk("owned", {31'h0, owned}, {31'h0, k != 2});
			m.read_txn(k == 0 ? own ^ 7'h01 : own, k != 1, 8'hff, aok);
			chk("no ack", {31'h0, aok}, 32'h0);
			rd(OFS_ISTAT, q);
			chk("start flag", q, {31'h0, k != 2});
		end
		summarize();
	end
endmodule // test_its_slave_tx
